// File: rtl/trds_pkg.sv
// Shared constants, types and helpers for the tape read data store sequencer.
// Assumes a single controller clock and an AXI4-Lite register master.
package trds_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int FRAME_W = 9;
  localparam int WORD_W = 32;
  localparam int REG_W = 32;
  localparam int STRB_W = 4;
  localparam int MOD_W = 3;
  localparam int ADDR_W = 8;
  localparam int INT_W = 3;
  localparam int SYNC_STAGES = 3;

  // ----------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_MODULUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_PARITY = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_OUT_WORD = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 8'h18;
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_IGNORE = 2;
  localparam int CTRL_REDUNDANT = 3;
  localparam int INT_WORD = 0;
  localparam int INT_PARITY = 1;
  localparam int INT_OVERRUN = 2;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [MOD_W-1:0] MOD_MAX = 3'h4;
  localparam logic [MOD_W-1:0] MOD_RST = 3'h4;
  localparam logic [INT_W-1:0] INT_RST = 3'h0;
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_PARITY = 2'h1;
  localparam logic [1:0] ERR_OVERRUN = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_WAIT = 7'h02,
    ST_CAPTURE = 7'h04,
    ST_CHECK = 7'h08,
    ST_FULLTEST = 7'h10,
    ST_XFER = 7'h20,
    ST_SPACE = 7'h40
  } trds_seq_t;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [REG_W-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } trds_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [REG_W-1:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } trds_axi_rsp_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Odd lateral parity: an even count of ones is an error
  function automatic logic trds_lat_err(input logic [FRAME_W-1:0] f);
    return ~(^f);
  endfunction : trds_lat_err

  // Modulus minus one, held to the range 0..MOD_MAX-1
  function automatic logic [MOD_W-1:0] trds_mod_m1(input logic [MOD_W-1:0] m);
    logic [MOD_W-1:0] r;
    r = m - 1'b1;
    if (m == 3'h0) begin
      r = 3'h0;
    end else if (m > MOD_MAX) begin
      r = MOD_MAX - 1'b1;
    end
    return r;
  endfunction : trds_mod_m1

  // Byte-lane merge of a write into an old value
  function automatic logic [REG_W-1:0] trds_merge(input logic [REG_W-1:0] old,
      input logic [REG_W-1:0] wd, input logic [STRB_W-1:0] st);
    logic [REG_W-1:0] r;
    r = old;
    for (int i = 0; i < STRB_W; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : trds_merge

endpackage : trds_pkg

// File: rtl/trds_sync.sv
// Three-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to aclk; output changes once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module trds_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Data
  input wire logic [W-1:0] d,
  output var logic [W-1:0] q
);
  import trds_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } trds_sync_t;

  trds_sync_t s;
  trds_sync_t next_s;

  always_comb begin
    next_s = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3) begin
      next_s.q = s.s3;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.q;

endmodule : trds_sync
`default_nettype wire

// File: rtl/trds_convert.sv
// Format converter for redundant-format frames.
// Assumes redundant data is recorded with its bit order reversed.
`timescale 1ns/10ps
`default_nettype none
module trds_convert (
  // Data
  input wire logic [trds_pkg::DATA_W-1:0] din,
  output logic [trds_pkg::DATA_W-1:0] dout
);
  import trds_pkg::*;

  always_comb begin
    dout = '0;
    for (int i = 0; i < DATA_W; i++) begin
      dout[i] = din[DATA_W-1-i];
    end
  end

endmodule : trds_convert
`default_nettype wire

// File: rtl/trds_top.sv
// Read data store sequencer with AXI4-Lite registers and interrupt.
// Assumes tape frame and strobe pins from the read channel, one clock aclk.
// Functional notes
// - Copy tape frame into frame accumulator
// - Clear data ready after frame capture
// - XOR frame into longitudinal parity accumulator
// - Lateral error unignored: space to gap, error
// - Redundant flag set: convert before storing frame
// - Buffer full when write equals read pointer
// - Buffer full: space to gap, report error
// - Not full, countdown nonzero: decrement, next frame
// - Countdown zero: examine output word loaded flag
// - Loaded: reload countdown modulus minus one, continue
// - Not loaded: start buffer to output transfer
// - At start preset countdown, clear parity
// - Store and read buffer in sequential order
`timescale 1ns/10ps
`default_nettype none
module trds_top #(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire trds_pkg::trds_axi_req_t axi_req,
  output var trds_pkg::trds_axi_rsp_t axi_rsp,
  // Tape read channel
  input wire logic [trds_pkg::FRAME_W-1:0] tape_frame,
  input wire logic tape_strobe,
  output logic transport_run,
  output logic space_to_gap,
  // Interrupt
  output logic irq
);
  import trds_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    trds_seq_t seq;
    logic strobe_prev;
    logic [FRAME_W-1:0] read_register;
    logic data_ready;
    logic [FRAME_W-1:0] frame_accumulator;
    logic [FRAME_W-1:0] longitudinal_parity_accumulator;
    logic [MOD_W-1:0] countdown;
    logic [MOD_W-1:0] xfer_count;
    logic [DEPTH-1:0][DATA_W-1:0] store;
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [WORD_W-1:0] assembly;
    logic [WORD_W-1:0] output_word_holding_register;
    logic loaded;
    logic run;
    logic space_to_gap;
    logic [1:0] err;
    logic ignore_lateral;
    logic redundant;
    logic [MOD_W-1:0] modulus;
    logic [INT_W-1:0] int_status;
    logic [INT_W-1:0] int_mask;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] awaddr;
    logic [REG_W-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [REG_W-1:0] rdata;
    logic [1:0] rresp;
  } trds_state_t;

  trds_state_t s;
  trds_state_t next_s;

  // ----------------------------------------------------------------
  // Pin synchroniser and format converter
  // ----------------------------------------------------------------
  logic [FRAME_W:0] pins_sync;
  logic [DATA_W-1:0] conv_out;
  logic lat_stop;
  logic do_write;
  logic start;
  logic stop;
  logic [REG_W-1:0] merged;
  logic [INT_W-1:0] events;

  trds_sync #(.W(FRAME_W + 1)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({tape_strobe, tape_frame}),
    .q(pins_sync)
  );

  trds_convert u_convert (
    .din(s.frame_accumulator[DATA_W-1:0]),
    .dout(conv_out)
  );

  assign lat_stop = trds_lat_err(s.frame_accumulator) & ~s.ignore_lateral;
  assign do_write = s.aw_held & s.w_held & ~s.bvalid;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    start = 1'b0;
    stop = 1'b0;
    events = '0;
    merged = '0;
    next_s.space_to_gap = 1'b0;
    next_s.strobe_prev = pins_sync[FRAME_W];
    // Register bus write
    if (axi_req.awvalid & ~s.aw_held) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid & ~s.w_held) begin
      next_s.w_held = 1'b1;
      next_s.wdata = axi_req.wdata;
      next_s.wstrb = axi_req.wstrb;
    end
    if (s.bvalid & axi_req.bready) begin
      next_s.bvalid = 1'b0;
    end
    if (do_write) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      case (s.awaddr)
        ADDR_CTRL: begin
          merged = trds_merge(REG_W'({s.redundant, s.ignore_lateral, 2'b00}), s.wdata, s.wstrb);
          start = merged[CTRL_START];
          stop = merged[CTRL_STOP];
          next_s.ignore_lateral = merged[CTRL_IGNORE];
          next_s.redundant = merged[CTRL_REDUNDANT];
        end
        ADDR_MODULUS: begin
          merged = trds_merge(REG_W'(s.modulus), s.wdata, s.wstrb);
          next_s.modulus = merged[MOD_W-1:0];
        end
        ADDR_INT_STATUS: begin
          merged = trds_merge(REG_W'(0), s.wdata, s.wstrb);
          next_s.int_status = s.int_status & ~merged[INT_W-1:0];
        end
        ADDR_INT_MASK: begin
          merged = trds_merge(REG_W'(s.int_mask), s.wdata, s.wstrb);
          next_s.int_mask = merged[INT_W-1:0];
        end
        ADDR_STATUS, ADDR_PARITY, ADDR_OUT_WORD: begin
          next_s.bresp = RESP_OKAY;
        end
        default: begin
          next_s.bresp = RESP_SLVERR;
        end
      endcase
    end
    // Register bus read
    if (s.rvalid & axi_req.rready) begin
      next_s.rvalid = 1'b0;
    end
    if (axi_req.arvalid & ~s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      case (axi_req.araddr)
        ADDR_CTRL: next_s.rdata = REG_W'({s.redundant, s.ignore_lateral, 2'b00});
        ADDR_MODULUS: next_s.rdata = REG_W'(s.modulus);
        ADDR_STATUS: next_s.rdata = REG_W'({s.err, s.data_ready, s.loaded, s.run, s.seq});
        ADDR_PARITY: next_s.rdata = REG_W'(s.longitudinal_parity_accumulator);
        ADDR_OUT_WORD: begin
          next_s.rdata = s.output_word_holding_register;
          next_s.loaded = 1'b0;
        end
        ADDR_INT_STATUS: next_s.rdata = REG_W'(s.int_status);
        ADDR_INT_MASK: next_s.rdata = REG_W'(s.int_mask);
        default: begin
          next_s.rdata = '0;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end
    // Sequencer
    case (s.seq)
      ST_IDLE: begin
        if (start) begin
          next_s.countdown = trds_mod_m1(s.modulus);
          next_s.longitudinal_parity_accumulator = '0;
          next_s.wptr = '0;
          next_s.rptr = '0;
          next_s.err = ERR_NONE;
          next_s.run = 1'b1;
          next_s.seq = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (s.data_ready) begin
          next_s.seq = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        next_s.frame_accumulator = s.read_register;
        next_s.data_ready = 1'b0;
        next_s.longitudinal_parity_accumulator =
          s.longitudinal_parity_accumulator ^ s.read_register;
        next_s.seq = ST_CHECK;
      end
      ST_CHECK: begin
        if (lat_stop) begin
          next_s.err = ERR_PARITY;
          events[INT_PARITY] = 1'b1;
          next_s.seq = ST_SPACE;
        end else begin
          if (s.redundant) begin
            next_s.store[s.wptr] = conv_out;
          end else begin
            next_s.store[s.wptr] = s.frame_accumulator[DATA_W-1:0];
          end
          next_s.wptr = s.wptr + 1'b1;
          next_s.seq = ST_FULLTEST;
        end
      end
      ST_FULLTEST: begin
        if (s.wptr == s.rptr) begin
          next_s.err = ERR_OVERRUN;
          events[INT_OVERRUN] = 1'b1;
          next_s.seq = ST_SPACE;
        end else if (s.countdown != 3'h0) begin
          next_s.countdown = s.countdown - 1'b1;
          next_s.seq = ST_WAIT;
        end else if (s.loaded) begin
          next_s.countdown = trds_mod_m1(s.modulus);
          next_s.seq = ST_WAIT;
        end else begin
          next_s.countdown = trds_mod_m1(s.modulus);
          next_s.xfer_count = trds_mod_m1(s.modulus);
          next_s.assembly = '0;
          next_s.seq = ST_XFER;
        end
      end
      ST_XFER: begin
        next_s.assembly = {s.assembly[WORD_W-DATA_W-1:0], s.store[s.rptr]};
        next_s.rptr = s.rptr + 1'b1;
        if (s.xfer_count == 3'h0) begin
          next_s.output_word_holding_register = {s.assembly[WORD_W-DATA_W-1:0], s.store[s.rptr]};
          next_s.loaded = 1'b1;
          events[INT_WORD] = 1'b1;
          next_s.seq = ST_WAIT;
        end else begin
          next_s.xfer_count = s.xfer_count - 1'b1;
        end
      end
      ST_SPACE: begin
        next_s.space_to_gap = 1'b1;
        next_s.run = 1'b0;
        next_s.seq = ST_IDLE;
      end
      default: begin
        next_s.seq = ST_IDLE;
      end
    endcase
    if (stop && s.seq != ST_IDLE) begin
      next_s.run = 1'b0;
      next_s.seq = ST_IDLE;
    end
    // Flags set by hardware win over clears
    if (pins_sync[FRAME_W] & ~s.strobe_prev) begin
      next_s.read_register = pins_sync[FRAME_W-1:0];
      next_s.data_ready = 1'b1;
    end
    next_s.int_status = next_s.int_status | events;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.seq <= ST_IDLE;
      s.modulus <= MOD_RST;
      s.int_mask <= INT_RST;
      s.bresp <= RESP_OKAY;
      s.rresp <= RESP_OKAY;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign axi_rsp.awready = ~s.aw_held;
  assign axi_rsp.wready = ~s.w_held;
  assign axi_rsp.bresp = s.bresp;
  assign axi_rsp.bvalid = s.bvalid;
  assign axi_rsp.arready = ~s.rvalid;
  assign axi_rsp.rdata = s.rdata;
  assign axi_rsp.rresp = s.rresp;
  assign axi_rsp.rvalid = s.rvalid;
  assign transport_run = s.run;
  assign space_to_gap = s.space_to_gap;
  assign irq = |(s.int_status & s.int_mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_capture_copy: assert property (((s.seq == ST_CAPTURE) && !stop) |=>
    (s.frame_accumulator == $past(s.read_register)) && (s.seq == ST_CHECK))
    else $error("frame not copied at capture");
  a_ready_clear: assert property (((s.seq == ST_CAPTURE) && !(pins_sync[FRAME_W]
    && !s.strobe_prev)) |=> !s.data_ready)
    else $error("data ready not cleared");
  a_parity_xor: assert property ((s.seq == ST_CAPTURE) |=>
    s.longitudinal_parity_accumulator ==
    ($past(s.longitudinal_parity_accumulator) ^ $past(s.read_register)))
    else $error("longitudinal parity wrong");
  a_parity_space: assert property (((s.seq == ST_CHECK) && lat_stop && !stop) |=>
    (s.seq == ST_SPACE) ##1 (space_to_gap && (s.err == ERR_PARITY)))
    else $error("parity error not spaced");
  a_ignore_pass: assert property (((s.seq == ST_CHECK) && s.ignore_lateral && !stop)
    |=> (s.seq == ST_FULLTEST))
    else $error("ignored error still stopped");
  a_store_conv: assert property (((s.seq == ST_CHECK) && !lat_stop && s.redundant) |=>
    s.store[$past(s.wptr)] == $past(conv_out))
    else $error("redundant frame not converted");
  a_full_space: assert property (((s.seq == ST_FULLTEST) && (s.wptr == s.rptr) && !stop)
    |=> (s.seq == ST_SPACE) ##1 (space_to_gap && (s.err == ERR_OVERRUN) && !transport_run))
    else $error("overrun not spaced");
  a_count_dec: assert property (((s.seq == ST_FULLTEST) && (s.wptr != s.rptr)
    && (s.countdown != 3'h0) && !stop) |=>
    (s.countdown == $past(s.countdown) - 1'b1) && (s.seq == ST_WAIT))
    else $error("countdown not decremented");
  a_word_reload: assert property (((s.seq == ST_FULLTEST) && (s.wptr != s.rptr)
    && (s.countdown == 3'h0) && s.loaded && !stop) |=>
    (s.countdown == trds_mod_m1(s.modulus)) && (s.seq == ST_WAIT))
    else $error("countdown not reloaded");
  a_xfer_start: assert property (((s.seq == ST_FULLTEST) && (s.wptr != s.rptr)
    && (s.countdown == 3'h0) && !s.loaded && !stop) |=> (s.seq == ST_XFER) ##[1:4]
    (s.seq == ST_WAIT) && s.loaded)
    else $error("word transfer not completed");
  a_start_preset: assert property (((s.seq == ST_IDLE) && start) |=>
    (s.countdown == trds_mod_m1(s.modulus)) && (s.longitudinal_parity_accumulator == '0))
    else $error("start preset missing");
  a_ptr_step: assert property (((s.seq == ST_XFER) && !stop) |=>
    s.rptr == $past(s.rptr) + 1'b1)
    else $error("read pointer not sequential");

  c_word_out: cover property ((s.seq == ST_XFER) ##1 s.loaded);
  c_parity_stop: cover property ((s.seq == ST_CHECK) && lat_stop);
  c_overrun: cover property ((s.seq == ST_FULLTEST) && (s.wptr == s.rptr));
  c_reload: cover property ((s.seq == ST_FULLTEST) && (s.countdown == 3'h0) && s.loaded);

endmodule : trds_top
`default_nettype wire

// File: verif/trds_tape_model.sv
// Behavioural tape read channel: presents one frame per request with a strobe.
// Assumes the bench raises go for one aclk cycle while busy is low.
`timescale 1ns/10ps
`default_nettype none
module trds_tape_model (
  // Clock
  input wire logic aclk,
  // Bench control
  input wire logic go,
  input wire logic [trds_pkg::FRAME_W-1:0] frame,
  output logic busy,
  // Read channel pins
  output logic [trds_pkg::FRAME_W-1:0] tape_frame,
  output logic tape_strobe
);
  import trds_pkg::*;

  initial begin
    busy = 1'b0;
    tape_frame = 9'h000;
    tape_strobe = 1'b0;
  end

  // Frame settles before the strobe, is held until the strobe falls, then the lines show its inverse
  always @(posedge aclk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      tape_frame <= frame;
      repeat (4) @(posedge aclk);
      tape_strobe <= 1'b1;
      repeat (8) @(posedge aclk);
      tape_strobe <= 1'b0;
      tape_frame <= ~frame;
      repeat (10) @(posedge aclk);
      busy <= 1'b0;
    end
  end
endmodule : trds_tape_model
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the read data store sequencer.
// Assumes the tape channel model and an AXI4-Lite master driven from here.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import trds_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  trds_axi_req_t req = '0;
  trds_axi_rsp_t rsp;
  logic [FRAME_W-1:0] tape_frame;
  logic [FRAME_W-1:0] fr = 9'h000;
  logic tape_strobe, transport_run, space_to_gap, irq, busy;
  logic go = 1'b0;
  logic [31:0] rd_data;
  logic [1:0] rd_resp, wr_resp;
  int num_errors = 0;
  int checks_done = 0;
  int space_cnt = 0;
  int sc;

  always #25 aclk = ~aclk;

  always @(posedge aclk) begin
    if (space_to_gap) space_cnt <= space_cnt + 1;
  end

  trds_top #(.DEPTH(8)) u_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .tape_frame(tape_frame), .tape_strobe(tape_strobe), .transport_run(transport_run),
    .space_to_gap(space_to_gap), .irq(irq));

  trds_tape_model u_tape (.aclk(aclk), .go(go), .frame(fr), .busy(busy),
    .tape_frame(tape_frame), .tape_strobe(tape_strobe));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [8:0] mk(input logic [7:0] d, input logic bad);
    return {(~^d) ^ bad, d};
  endfunction : mk

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!(req.bready && rsp.bvalid));
    wr_resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!(req.rready && rsp.rvalid));
    rd_data = rsp.rdata;
    rd_resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd

  task automatic send(input logic [8:0] f);
    @(posedge aclk);
    go <= 1'b1;
    fr <= f;
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
    while (busy) @(posedge aclk);
  endtask : send

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(ADDR_MODULUS);
    chk("modulus", rd_data, 32'h4);
    rd(ADDR_INT_MASK);
    chk("mask", rd_data, 32'h0);
    rd(ADDR_STATUS);
    chk("status", rd_data, 32'h1);
    rd(8'h1c);
    chk("unmapped rresp", {30'h0, rd_resp}, {30'h0, RESP_SLVERR});
    chk("unmapped rdata", rd_data, 32'h0);
    wr(8'h1c, 32'h1);
    chk("unmapped bresp", {30'h0, wr_resp}, {30'h0, RESP_SLVERR});
    $display("test reset done");
  endtask : t_reset

  task automatic t_word;
    logic [7:0] b[4];
    logic [8:0] par;
    b = '{8'h12, 8'h34, 8'h56, 8'h78};
    par = 9'h000;
    wr(ADDR_INT_MASK, 32'h1);
    wr(ADDR_CTRL, 32'h1);
    chk("run", {31'h0, transport_run}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      send(mk(b[i], 1'b0));
      par = par ^ mk(b[i], 1'b0);
      rd(ADDR_STATUS);
      chk("ready", {31'h0, rd_data[9]}, 32'h0);
      if (i == 2) chk("loaded early", {31'h0, rd_data[8]}, 32'h0);
    end
    chk("loaded", {31'h0, rd_data[8]}, 32'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(ADDR_PARITY);
    chk("parity", rd_data, {23'h0, par});
    rd(ADDR_OUT_WORD);
    chk("word", rd_data, 32'h12345678);
    wr(ADDR_INT_STATUS, 32'h1);
    chk("irq clear", {31'h0, irq}, 32'h0);
    $display("test word done");
  endtask : t_word

  task automatic t_conv;
    wr(ADDR_CTRL, 32'h2);
    chk("stopped", {31'h0, transport_run}, 32'h0);
    wr(ADDR_MODULUS, 32'h1);
    wr(ADDR_CTRL, 32'h9);
    send(mk(8'h01, 1'b0));
    rd(ADDR_OUT_WORD);
    chk("converted", rd_data, 32'h80);
    rd(ADDR_PARITY);
    chk("parity fresh", rd_data, {23'h0, mk(8'h01, 1'b0)});
    $display("test convert done");
  endtask : t_conv

  task automatic t_parity;
    wr(ADDR_CTRL, 32'h1);
    sc = space_cnt;
    send(mk(8'h33, 1'b1));
    chk("space", space_cnt, sc + 1);
    chk("run off", {31'h0, transport_run}, 32'h0);
    rd(ADDR_STATUS);
    chk("err", {30'h0, rd_data[11:10]}, {30'h0, ERR_PARITY});
    rd(ADDR_INT_STATUS);
    chk("int parity", rd_data & 32'h2, 32'h2);
    wr(ADDR_INT_STATUS, 32'h7);
    wr(ADDR_CTRL, 32'h5);
    sc = space_cnt;
    send(mk(8'h5a, 1'b1));
    chk("ignored", space_cnt, sc);
    chk("run on", {31'h0, transport_run}, 32'h1);
    rd(ADDR_OUT_WORD);
    chk("stored", rd_data, 32'h5a);
    $display("test parity done");
  endtask : t_parity

  task automatic t_over;
    sc = space_cnt;
    for (int i = 1; i < 9; i++) send(mk(i[7:0], 1'b0));
    chk("not full", space_cnt, sc);
    chk("still run", {31'h0, transport_run}, 32'h1);
    send(mk(8'h09, 1'b0));
    chk("full space", space_cnt, sc + 1);
    chk("full stop", {31'h0, transport_run}, 32'h0);
    rd(ADDR_STATUS);
    chk("err over", {30'h0, rd_data[11:10]}, {30'h0, ERR_OVERRUN});
    rd(ADDR_INT_STATUS);
    chk("int overrun", rd_data & 32'h4, 32'h4);
    rd(ADDR_OUT_WORD);
    chk("first word", rd_data, 32'h01);
    $display("test overrun done");
  endtask : t_over

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_word();
    t_conv();
    t_parity();
    t_over();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
